/* rtl/rtu_map.svh */
`ifndef RTU_MAP_SVH
`define RTU_MAP_SVH
// Printed offsets are register indices; byte address is four times these.
`define RTU_IDX_T0_HIGH 8'h12
`define RTU_IDX_T0_LOW 8'h13
`define RTU_IDX_SETUP 8'h14
`define RTU_IDX_RELOAD_HIGH 8'h15
`define RTU_IDX_RELOAD_LOW 8'h16
`define RTU_IDX_RUN 8'h20
`define RTU_IDX_IRQ_STATUS 8'h21
`define RTU_IDX_IRQ_ENABLE 8'h22
`define RTU_IDX_IRQ_CLEAR 8'h23
// Field positions of timer1_setup.
`define RTU_SETUP_STOPRX 7
`define RTU_SETUP_START_HI 5
`define RTU_SETUP_START_LO 4
`define RTU_SETUP_AUTO 3
`define RTU_SETUP_CLK_HI 1
`define RTU_SETUP_CLK_LO 0
// Writable bits of timer1_setup; bits 6 and 2 read as zero.
`define RTU_SETUP_MASK 8'hBB
// Run register fields.
`define RTU_RUN_STATUS 1
`define RTU_RUN_WREN 0
// Reset values.
`define RTU_SETUP_RESET 8'h00
`define RTU_RELOAD_RESET 16'h0000
// Bits received before the stop-on-receive condition fires.
`define RTU_STOPRX_BITS 4
`endif

/* rtl/rtu_pkg.sv */
package rtu_pkg;
  typedef enum logic [1:0] {
    RTU_START_MANUAL,
    RTU_START_TX_END,
    RTU_START_TRIM,
    RTU_START_TRIM_UF
  } rtu_start_t;
  typedef enum logic [1:0] {
    RTU_CLK_FULL,
    RTU_CLK_DIV,
    RTU_CLK_TIMER0,
    RTU_CLK_TIMER2
  } rtu_clk_t;
  typedef enum {
    RTU_IDLE,
    RTU_COUNT,
    RTU_TRIM_WAIT
  } rtu_state_t;
endpackage

/* rtl/rtu_timer.sv */
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "rtu_map.svh"
// Behaviour
// RULE_01: Timer 0 count is readable as read-only high and low bytes.
// RULE_02: Software must not read count bytes while a frame is received.
// RULE_03: Stop-on-receive halts timer 1 after the first four bits.
// RULE_04: Stop-on-receive is ignored in either trimming mode.
// RULE_05: Start mode 00 never starts timer 1 by itself.
// RULE_06: Start mode 01 starts timer 1 when transmission ends.
// RULE_07: Modes 10 and 11 trim on rising edges, without/with underflow.
// RULE_08: Auto-restart set reloads and keeps counting at zero.
// RULE_09: Auto-restart clear stops the timer after reaching zero.
// RULE_10: Every underflow sets the timer 1 interrupt flag.
// RULE_11: Clock select 00 uses full clock, 01 the divided tick.
// RULE_12: Clock select 10 cascades timer 0, 11 cascades timer 2.
// RULE_13: Each start event loads the counter from both reload bytes.
// RULE_14: Reload writes affect only the next start event; the code also loads them into the count at each auto-restart underflow.
// RULE_15: Reload value is 16 bits, high and low bytes read/write.
// RULE_16: Running bit changes by write only with write-enable set.
// RULE_17: Counter decrements per tick; decrement at zero is underflow.
module rtu_timer #(
  parameter int CW = 16 // Counter width.
) (
  input wire logic core_clk, // System clock, 10 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state except the reset synchroniser while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic [15:0] timer0_count, // Live timer 0 count.
  input wire logic timer0_underflow, // Timer 0 underflow pulse.
  input wire logic timer2_underflow, // Timer 2 underflow pulse.
  input wire logic div_tick, // Divided-rate tick pulse.
  input wire logic tx_done, // End of transmission pulse.
  input wire logic rx_bit, // One received bit pulse.
  input wire logic rx_active, // Frame reception in progress.
  input wire logic low_freq_oscillator, // Oscillator pin being trimmed.
  output logic timer1_running_status, // Timer 1 is counting or waiting for a trim edge.
  output logic timer1_underflow_pulse, // One-cycle underflow event.
  output logic irq // Level interrupt.
);
  import rtu_pkg::*;

  logic rst_s1;
  logic rst_n;
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic [7:0] timer1_setup;
  logic [CW-1:0] timer1_reload_value;
  logic [CW-1:0] count;
  logic irq_status;
  logic irq_enable;
  logic [2:0] rx_bits;
  rtu_state_t state;
  rtu_start_t start_mode;
  rtu_clk_t clock_select;
  logic stop_on_receive;
  logic auto_reload_enable;
  logic [7:0] idx;
  logic wr;
  logic rd;
  logic mapped;
  logic tick;
  logic osc_rise;
  logic trim_mode;
  logic sw_start;
  logic sw_stop;
  logic hw_start;
  logic rx_stop;
  logic start_evt;
  logic underflow;
  logic next_running;
  logic [31:0] next_rdata;

  // Reset is released through two flops so its removal is synchronous.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // The oscillator pin is asynchronous; only osc_s2 onward is inspected.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else if (clk_en) begin
      osc_s1 <= low_freq_oscillator;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // Field decode of the setup register.
  assign stop_on_receive = timer1_setup[`RTU_SETUP_STOPRX];
  assign start_mode = rtu_start_t'(
    timer1_setup[`RTU_SETUP_START_HI:`RTU_SETUP_START_LO]);
  assign auto_reload_enable = timer1_setup[`RTU_SETUP_AUTO];
  assign clock_select = rtu_clk_t'(
    timer1_setup[`RTU_SETUP_CLK_HI:`RTU_SETUP_CLK_LO]);
  assign trim_mode = start_mode == RTU_START_TRIM ||
                     start_mode == RTU_START_TRIM_UF;
  assign osc_rise = osc_s2 & ~osc_s3;

  // APB decode; every access completes with zero wait states.
  assign idx = paddr[9:2];
  // Misaligned or unmapped writes are refused, so they must not land.
  assign wr = psel & penable & pwrite & clk_en & mapped;
  assign rd = psel & penable & ~pwrite & clk_en;
  assign mapped = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
    (idx inside {`RTU_IDX_T0_HIGH, `RTU_IDX_T0_LOW, `RTU_IDX_SETUP,
     `RTU_IDX_RELOAD_HIGH, `RTU_IDX_RELOAD_LOW, `RTU_IDX_RUN,
     `RTU_IDX_IRQ_STATUS, `RTU_IDX_IRQ_ENABLE, `RTU_IDX_IRQ_CLEAR});

  // Tick source selection.
  always_comb begin
    case (clock_select)
      RTU_CLK_FULL: tick = 1'b1; // RULE_11
      RTU_CLK_DIV: tick = div_tick; // RULE_11
      RTU_CLK_TIMER0: tick = timer0_underflow; // RULE_12
      RTU_CLK_TIMER2: tick = timer2_underflow; // RULE_12
      default: tick = 1'b0;
    endcase
  end

  // Start and stop causes.
  assign sw_start = wr && idx == `RTU_IDX_RUN &&
    pwdata[`RTU_RUN_WREN] && pwdata[`RTU_RUN_STATUS]; // RULE_16
  assign sw_stop = wr && idx == `RTU_IDX_RUN &&
    pwdata[`RTU_RUN_WREN] && !pwdata[`RTU_RUN_STATUS]; // RULE_16
  assign hw_start = (start_mode == RTU_START_TX_END && tx_done) ||
    (trim_mode && state == RTU_TRIM_WAIT && osc_rise); // RULE_06 RULE_07
  assign start_evt = (sw_start || hw_start) && state != RTU_COUNT;
  // A fourth received bit stops the count unless trimming is active.
  assign rx_stop = stop_on_receive && !trim_mode && rx_bit &&
    rx_bits == 3'(`RTU_STOPRX_BITS - 1); // RULE_03 RULE_04
  // Underflow is a decrement taken while the count is at zero.
  assign underflow = state == RTU_COUNT && tick && count == '0 &&
    !(start_mode == RTU_START_TRIM); // RULE_17 RULE_07

  // Received-bit counter, cleared at each start so the first four count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_bits <= 3'h0;
    end else if (clk_en) begin
      if (start_evt) begin
        rx_bits <= 3'h0;
      end else if (state == RTU_COUNT && rx_bit &&
                   rx_bits != 3'(`RTU_STOPRX_BITS)) begin
        rx_bits <= rx_bits + 3'h1;
      end
    end
  end

  // Timer sequencer; trimming arms, then runs between two rising edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RTU_IDLE;
      count <= '0;
    end else if (clk_en) begin
      case (state)
        RTU_IDLE: begin
          if (sw_start && trim_mode) begin
            state <= RTU_TRIM_WAIT; // RULE_07
          end else if (start_evt) begin
            state <= RTU_COUNT; // RULE_05 RULE_06
            count <= timer1_reload_value; // RULE_13
          end
        end
        RTU_TRIM_WAIT: begin
          if (sw_stop) begin
            state <= RTU_IDLE;
          end else if (osc_rise) begin
            state <= RTU_COUNT;
            count <= timer1_reload_value; // RULE_13
          end
        end
        RTU_COUNT: begin
          if (sw_stop || rx_stop || (trim_mode && osc_rise)) begin
            state <= RTU_IDLE; // RULE_03 RULE_07
          end else if (underflow) begin
            if (auto_reload_enable) begin
              count <= timer1_reload_value; // RULE_08
            end else begin
              state <= RTU_IDLE; // RULE_09
            end
          end else if (tick && count != '0) begin
            count <= count - CW'(1); // RULE_17
          end
        end
        default: state <= RTU_IDLE;
      endcase
    end
  end

  // Software-written registers; reload bytes never touch the live count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_setup <= `RTU_SETUP_RESET;
      timer1_reload_value <= `RTU_RELOAD_RESET;
      irq_enable <= 1'b0;
    end else if (wr) begin
      case (idx)
        `RTU_IDX_SETUP: timer1_setup <= pwdata[7:0] & `RTU_SETUP_MASK;
        `RTU_IDX_RELOAD_HIGH: timer1_reload_value[15:8] <= pwdata[7:0]; // RULE_15
        `RTU_IDX_RELOAD_LOW: timer1_reload_value[7:0] <= pwdata[7:0]; // RULE_15
        `RTU_IDX_IRQ_ENABLE: irq_enable <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Sticky underflow flag; a set in the clear cycle wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 1'b0;
    end else if (clk_en) begin
      if (underflow) begin
        irq_status <= 1'b1; // RULE_10
      end else if (wr && idx == `RTU_IDX_IRQ_CLEAR && pwdata[0]) begin
        irq_status <= 1'b0;
      end
    end
  end

  // Next value of the registered running status output.
  always_comb begin
    next_running = 1'b0;
    if (clk_en) begin
      next_running = state != RTU_IDLE;
    end else begin
      next_running = timer1_running_status;
    end
  end

  // Read mux; count bytes are sampled live, so reads mid-frame may tear.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      `RTU_IDX_T0_HIGH: next_rdata[7:0] = timer0_count[15:8]; // RULE_01
      `RTU_IDX_T0_LOW: next_rdata[7:0] = timer0_count[7:0]; // RULE_01
      `RTU_IDX_SETUP: next_rdata[7:0] = timer1_setup;
      `RTU_IDX_RELOAD_HIGH: next_rdata[7:0] = timer1_reload_value[15:8];
      `RTU_IDX_RELOAD_LOW: next_rdata[7:0] = timer1_reload_value[7:0];
      `RTU_IDX_RUN: next_rdata[`RTU_RUN_STATUS] = state != RTU_IDLE;
      `RTU_IDX_IRQ_STATUS: next_rdata[0] = irq_status;
      `RTU_IDX_IRQ_ENABLE: next_rdata[0] = irq_enable;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Registered APB answer: ready rises in the access cycle's setup edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite & mapped) ? next_rdata
                                                    : 32'h0000_0000;
    end
  end

  // Registered status and interrupt outputs.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_running_status <= 1'b0;
      timer1_underflow_pulse <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      timer1_running_status <= next_running;
      timer1_underflow_pulse <= underflow & clk_en;
      irq <= irq_status & irq_enable;
    end
  end

  // Checks.
  chk_uf_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    underflow |=> irq_status) else $error("underflow did not set flag"); // RULE_10
  chk_reload_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && underflow && auto_reload_enable && !sw_stop && !rx_stop &&
    !trim_mode |=> state == RTU_COUNT && count == $past(timer1_reload_value))
    else $error("auto reload failed"); // RULE_08
  chk_oneshot_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && underflow && !auto_reload_enable |=> state == RTU_IDLE)
    else $error("one-shot did not stop"); // RULE_09
  chk_rx_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rx_stop && state == RTU_COUNT |=> state == RTU_IDLE)
    else $error("stop on receive failed"); // RULE_03
  chk_trim_no_rx: assert property (@(posedge core_clk) disable iff (!rst_n)
    trim_mode |-> !rx_stop) else $error("rx stop in trim"); // RULE_04
  chk_manual_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == RTU_IDLE && start_mode == RTU_START_MANUAL &&
    !sw_start |=> state == RTU_IDLE) else $error("self start"); // RULE_05
  chk_tx_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == RTU_IDLE && start_mode == RTU_START_TX_END && tx_done
    |=> state == RTU_COUNT && count == $past(timer1_reload_value))
    else $error("no start at tx end"); // RULE_06 RULE_13
  chk_decrement: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == RTU_COUNT && tick && count != '0 && !sw_stop &&
    !rx_stop && !(trim_mode && osc_rise) |=> count == $past(count) - CW'(1))
    else $error("bad decrement"); // RULE_17 RULE_14
  chk_run_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr && idx == `RTU_IDX_RUN && !pwdata[`RTU_RUN_WREN] && state == RTU_IDLE
    && !hw_start |=> state == RTU_IDLE) else $error("run w/o enable"); // RULE_16
  chk_t0_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && psel && !penable && !pwrite && idx == `RTU_IDX_T0_LOW &&
    mapped |=> prdata[7:0] == $past(timer0_count[7:0]))
    else $error("t0 low wrong"); // RULE_01
endmodule

/* verif/reader_timer_unit_tb.sv */
`timescale 1ns/100ps
`include "rtu_map.svh"
module reader_timer_unit_tb;
  import rtu_pkg::*;
  localparam logic [7:0] I_SET = `RTU_IDX_SETUP;
  localparam logic [7:0] I_RH = `RTU_IDX_RELOAD_HIGH;
  localparam logic [7:0] I_RL = `RTU_IDX_RELOAD_LOW;
  localparam logic [7:0] I_RUN = `RTU_IDX_RUN;
  localparam logic [7:0] I_ST = `RTU_IDX_IRQ_STATUS;
  localparam logic [7:0] I_EN = `RTU_IDX_IRQ_ENABLE;
  localparam logic [7:0] I_CLR = `RTU_IDX_IRQ_CLEAR;
  logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [31:0] seed = 32'hB992B6CB;
  logic pready, pslverr, run_st, uf, irq, err, osc = 0;
  // No frame is ever received while the count bytes are read.
  logic rx_act = 1'b0;
  logic [15:0] t0_cnt = 16'h0000;
  logic [4:0] pv = 5'h00;
  int n_mismatch = 0, samples_checked = 0, c, k;
  rtu_timer #(.CW(16)) rtu_timer_inst (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer0_count(t0_cnt), .timer0_underflow(pv[3]),
    .timer2_underflow(pv[4]), .div_tick(pv[2]), .tx_done(pv[0]),
    .rx_bit(pv[1]), .rx_active(rx_act), .low_freq_oscillator(osc),
    .timer1_running_status(run_st), .timer1_underflow_pulse(uf), .irq(irq));
  // Free-running core clock at 10 MHz.
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // Xorshift keeps the random stream repeatable across runs.
  function automatic logic [31:0] rnd();
    logic [31:0] x;
    x = seed ^ (seed << 13);
    x = x ^ (x >> 17);
    seed = x ^ (x << 5);
    return seed;
  endfunction
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  // One APB transfer; pready and data are taken at the same rising edge.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, input logic [1:0] lo);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, lo};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk_flag(1'b0, 1'b1, "apb hang");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Registered outputs follow a write by up to two edges.
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 2'h0);
  endtask
  task automatic rdr(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0, 2'h0);
  endtask
  // Pulse one event input n times, each for a single cycle.
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge core_clk);
      pv <= 5'h01 << s;
      @(posedge core_clk);
      pv <= 5'h00;
    end
  endtask
  // The oscillator pin is synchronised, so each level is held a while.
  task automatic osc_rise();
    @(posedge core_clk);
    osc <= 1'b1;
    repeat (4) @(posedge core_clk);
    osc <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wait_uf(input int mx);
    c = 0;
    while (uf !== 1'b1 && c < mx) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  task automatic arm(input logic [7:0] s, input logic [15:0] r);
    wr(I_RUN, 32'h1);
    wr(I_RH, {24'h0, r[15:8]});
    wr(I_RL, {24'h0, r[7:0]});
    wr(I_SET, {24'h0, s});
    wr(I_CLR, 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdr(I_SET);
    chk_word(rd, {24'h0, `RTU_SETUP_RESET}, "setup reset");
    rdr(I_RL);
    chk_word(rd, 32'h0, "reload reset");
    apb(1'b0, 8'h30, 32'h0, 2'h0);
    chk_flag(err, 1'b1, "unmapped err");
    chk_word(rd, 32'h0, "unmapped data");
    apb(1'b1, I_SET, 32'hFF, 2'h1);
    chk_flag(err, 1'b1, "misaligned err");
    rdr(I_SET);
    chk_word(rd, 32'h0, "misaligned write ignored");
    // Random counts and register contents, read back byte by byte.
    for (k = 0; k < 4; k++) begin
      v = rnd();
      t0_cnt <= v[15:0];
      rdr(`RTU_IDX_T0_HIGH);
      chk_word(rd, {24'h0, v[15:8]}, "t0 high");
      rdr(`RTU_IDX_T0_LOW);
      chk_word(rd, {24'h0, v[7:0]}, "t0 low");
      wr(I_RH, v);
      wr(I_RL, v >> 8);
      wr(I_SET, v >> 16);
      rdr(I_RH);
      chk_word(rd, {24'h0, v[7:0]}, "reload high");
      rdr(I_RL);
      chk_word(rd, {24'h0, v[15:8]}, "reload low");
      rdr(I_SET);
      chk_word(rd, {24'h0, v[23:16] & `RTU_SETUP_MASK}, "setup rw");
    end
    // Status bit without its write enable, and tx end in manual mode.
    arm(8'h00, 16'd5);
    wr(I_RUN, 32'h2);
    chk_flag(run_st, 1'b0, "run without enable");
    pulse(0, 1);
    repeat (3) @(negedge core_clk);
    chk_flag(run_st, 1'b0, "manual ignores tx end");
    wr(I_EN, 32'h1);
    wr(I_RUN, 32'h3);
    settle();
    chk_flag(run_st, 1'b1, "sw start");
    wait_uf(40);
    chk_flag(c < 40, 1'b1, "one shot underflow");
    repeat (2) @(negedge core_clk);
    chk_flag(irq, 1'b1, "irq raised");
    wait_uf(40);
    chk_word(c, 40, "no second underflow");
    chk_flag(run_st, 1'b0, "stopped at zero");
    wr(I_EN, 32'h0);
    settle();
    chk_flag(irq, 1'b0, "irq masked");
    rdr(I_ST);
    chk_word(rd, 32'h1, "status sticky");
    wr(I_CLR, 32'h1);
    rdr(I_ST);
    chk_word(rd, 32'h0, "status cleared");
    // Auto reload: period between underflows is reload plus one.
    for (k = 0; k < 3; k++) begin
      v = (k == 0) ? 32'h0 : (rnd() & 32'h1F) + 1;
      arm(8'h08, v[15:0]);
      wr(I_RUN, 32'h3);
      wait_uf(100);
      @(negedge core_clk);
      wait_uf(100);
      chk_word(c, v, "auto reload period");
    end
    // Divided tick and cascaded sources each need reload plus one events.
    for (k = 1; k < 4; k++) begin
      arm(k[7:0], 16'd2);
      wr(I_RUN, 32'h3);
      pulse(k + 1, 2);
      rdr(I_ST);
      chk_word(rd, 32'h0, "early underflow");
      pulse(k + 1, 1);
      wait_uf(6);
      chk_flag(c < 6, 1'b1, "tick source underflow");
    end
    // Start on tx end, with and without stop on receive.
    for (k = 0; k < 2; k++) begin
      arm(k ? 8'h10 : 8'h90, 16'hFFFF);
      pulse(0, 1);
      repeat (3) @(negedge core_clk);
      chk_flag(run_st, 1'b1, "tx end start");
      pulse(1, 3);
      chk_flag(run_st, 1'b1, "three bits run");
      pulse(1, 1);
      repeat (3) @(negedge core_clk);
      chk_flag(run_st, k[0], "fourth bit");
    end
    // Trimming modes ignore stop on receive; only mode 11 underflows.
    for (k = 2; k < 4; k++) begin
      // Reload long enough that mode 11 underflows after the rx pulses.
      arm(8'h80 | (k[7:0] << 4), 16'd20);
      wr(I_RUN, 32'h3);
      osc_rise();
      chk_flag(run_st, 1'b1, "trim started");
      pulse(1, 4);
      chk_flag(run_st, 1'b1, "trim ignores rx");
      wait_uf(20);
      chk_flag(c < 20, k == 3, "trim underflow");
      osc_rise();
      chk_flag(run_st, 1'b0, "trim stop edge");
    end
    test_done();
  end
endmodule
